// ---- hdl/dhdc_consts.svh ----
// Purpose: named constants for the detector health and data collection block
// Assumes: 25 MHz core clock, byte addresses on the register bus
// Notes:   definitions only
`ifndef DHDC_CONSTS_SVH
`define DHDC_CONSTS_SVH

`define DHDC_CLK_HZ        25000000
`define DHDC_TICK_MS       100
`define DHDC_TICKS_PER_SEC 4'hA
`define DHDC_SECS_PER_MIN  6'h3C
`define DHDC_RST_TICKS     4'h5

`define DHDC_OFF_CTRL      8'h00
`define DHDC_OFF_MASKS     8'h04
`define DHDC_OFF_AVGLEN    8'h08
`define DHDC_OFF_CMD       8'h0C
`define DHDC_OFF_RACT      8'h10
`define DHDC_OFF_ALARM     8'h14
`define DHDC_OFF_SEQ       8'h18
`define DHDC_OFF_VEND      8'h1C
`define DHDC_OFF_DUR       8'h20
`define DHDC_OFF_PEND      8'h24
`define DHDC_BASE_THR      4'h4
`define DHDC_BASE_FLT      4'h6
`define DHDC_BASE_DATA     4'h8

`define DHDC_F_NOACT       0
`define DHDC_F_MAXPRES     1
`define DHDC_F_ERRATIC     2
`define DHDC_F_COMM        3
`define DHDC_F_CONFIG      4
`define DHDC_F_OTHER       5
`define DHDC_CMD_DIAG      8

`define DHDC_PER_OFF       16'h0000
`define DHDC_PER_MAX       16'h0E10
`define DHDC_PER_VEH       16'hFFFE
`define DHDC_PER_CYCLE     16'hFFFF
`define DHDC_CNT_MAX       16'hFFFF
`define DHDC_BYTE_MAX      8'hFF
`define DHDC_OCC_FULL      40'h00000000C8
`define DHDC_SPD_SCALE     40'h0000000024
`define DHDC_SPD_DIV       40'h0000000064
`define DHDC_AVGLEN_RST    12'h1C2
`endif

// ---- hdl/dhdc_pkg.sv ----
// Purpose: shared types of the detector health and data collection block
// Assumes: constants live in dhdc_consts.svh
// Notes:   nothing here is imported; use dhdc_pkg::name
package dhdc_pkg;
   typedef enum logic {DHDC_BUS_IDLE, DHDC_BUS_ANSWER} dhdc_bus_t;
   typedef logic [5:0] dhdc_det_vec_t;
endpackage : dhdc_pkg

// ---- hdl/dhdc_top.sv ----
// Purpose: detector health, control and per-period data collection
// Assumes: detectors 0..3 vehicle, 4..5 pedestrian; contact pins asynchronous
// Notes:   Avalon-MM slave, one wait state on every access
`timescale 1ns/1ns
`include "dhdc_consts.svh"

//Contract
// - report vehicle alarms, drop inactive ones
// - controller flags vehicle faults, six reasons
// - no-activity, max-presence, erratic fault timing
// - report detector-signalled vehicle fault reasons
// - report pedestrian alarms, clear ended ones
// - controller flags pedestrian faults, six reasons
// - vehicle detector reset, self-returning
// - pedestrian detector reset, self-returning
// - diagnostic reset clears fault counters, keeps thresholds
// - vehicle remote actuation, cleared on backup
// - pedestrian remote actuation, cleared on backup
// - vehicle sequence number increments per period
// - per-period vehicle volume 0..65535
// - volume counts only physical detections
// - occupancy in half-percent steps per period
// - average speed km/h, 0..255 per period
// - record local end time of period
// - report sample duration in effect
// - separate pedestrian sequence number
// - period code: off, seconds, cycle length
// - zero threshold disables that diagnostic
module dhdc_top #(
   parameter int TICK_CYCLES = (`DHDC_CLK_HZ / 1000) * `DHDC_TICK_MS
) (
   input  wire  logic        core_clk,
   input  wire  logic        reset_n,
   input  wire  logic [7:0]  avs_address,
   input  wire  logic        avs_read,
   input  wire  logic        avs_write,
   input  wire  logic [31:0] avs_writedata,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   input  wire  logic [3:0]  vehDetIn,
   input  wire  logic [1:0]  pedDetIn,
   input  wire  logic [5:0]  detCommFail,
   input  wire  logic [5:0]  detOtherFault,
   input  wire  logic [5:0]  detPresent,
   input  wire  logic [19:0] vehDetFaultIn,
   input  wire  logic        backupMode,
   input  wire  logic        coordActive,
   input  wire  logic [15:0] cycleLength,
   input  wire  logic [31:0] localTime,
   output logic [3:0]        vehDetReset,
   output logic [1:0]        pedDetReset,
   output logic [3:0]        vehCall,
   output logic [1:0]        pedCall
);

   localparam int SW = 45;

   // effective period in seconds, 0 when sampling is off
   function automatic logic [15:0] periodSecs(input logic [15:0] code, input logic [15:0] vehEff,
                                              input logic coord, input logic [15:0] cyc);
      logic [15:0] r;
      r = `DHDC_PER_OFF;
      if (code == `DHDC_PER_CYCLE) begin
         if (coord && cyc != `DHDC_PER_OFF)
            r = (cyc > `DHDC_PER_MAX) ? `DHDC_PER_MAX : cyc;
      end else if (code == `DHDC_PER_VEH) begin
         r = vehEff;
      end else if (code <= `DHDC_PER_MAX) begin
         r = code;
      end
      return r;
   endfunction : periodSecs

   function automatic logic [7:0] occCalc(input logic [15:0] on, input logic [15:0] total);
      logic [39:0] q;
      q = 40'h0;
      if (total != 16'h0)
         q = ({24'h0, on} * `DHDC_OCC_FULL) / {24'h0, total};
      return q[7:0];
   endfunction : occCalc

   function automatic logic [7:0] spdCalc(input logic [15:0] vol, input logic [11:0] len,
                                          input logic [15:0] on);
      logic [39:0] q;
      q = 40'h0;
      if (on != 16'h0)
         q = ({24'h0, vol} * {28'h0, len} * `DHDC_SPD_SCALE) / ({24'h0, on} * `DHDC_SPD_DIV);
      return (q > {32'h0, `DHDC_BYTE_MAX}) ? `DHDC_BYTE_MAX : q[7:0];
   endfunction : spdCalc

   // pin synchronisers: three stages, accept when stages two and three agree
   logic [SW-1:0] syncS1Reg, syncS2Reg, syncS3Reg, syncFiltReg;
   wire  [SW-1:0] pinRaw = {backupMode, vehDetFaultIn, detPresent, detOtherFault, detCommFail,
                             pedDetIn, vehDetIn};
   wire  [SW-1:0] syncFiltNext = (syncS2Reg ~^ syncS3Reg) & syncS3Reg | (syncS2Reg ^ syncS3Reg) & syncFiltReg;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         syncS1Reg   <= '0;
         syncS2Reg   <= '0;
         syncS3Reg   <= '0;
         syncFiltReg <= '0;
      end else begin
         syncS1Reg   <= pinRaw;
         syncS2Reg   <= syncS1Reg;
         syncS3Reg   <= syncS2Reg;
         syncFiltReg <= syncFiltNext;
      end
   end
   wire dhdc_pkg::dhdc_det_vec_t detPhys = syncFiltReg[5:0];
   wire dhdc_pkg::dhdc_det_vec_t commF   = syncFiltReg[11:6];
   wire dhdc_pkg::dhdc_det_vec_t otherF  = syncFiltReg[17:12];
   wire dhdc_pkg::dhdc_det_vec_t present = syncFiltReg[23:18];
   wire [19:0] detRep  = syncFiltReg[43:24];
   wire        backup  = syncFiltReg[44];

   // time base: tenth, second and minute enables
   logic [31:0] divReg;
   logic [3:0]  tenthReg;
   logic [5:0]  secReg;
   logic        tickReg, secTickReg, minTickReg;
   wire         tickNow = (divReg == TICK_CYCLES - 1);
   wire         secNow  = tickNow && (tenthReg == `DHDC_TICKS_PER_SEC - 4'h1);
   wire         minNow  = secNow && (secReg == `DHDC_SECS_PER_MIN - 6'h1);
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         divReg <= '0; tenthReg <= '0; secReg <= '0;
         tickReg <= 1'b0; secTickReg <= 1'b0; minTickReg <= 1'b0;
      end else begin
         divReg     <= tickNow ? 32'h0 : divReg + 32'h1;
         tenthReg   <= secNow ? 4'h0 : (tickNow ? tenthReg + 4'h1 : tenthReg);
         secReg     <= minNow ? 6'h0 : (secNow ? secReg + 6'h1 : secReg);
         tickReg    <= tickNow;
         secTickReg <= secNow;
         minTickReg <= minNow;
      end
   end

   // software registers
   logic [31:0] ctrlReg, masksReg;
   logic [11:0] avgLenReg;
   logic [31:0] thrReg [6];
   dhdc_pkg::dhdc_det_vec_t ractReg, rstOutReg;
   logic [3:0]  rstTmrReg;
   logic        diagReg, backupPrevReg;
   dhdc_pkg::dhdc_bus_t busReg;
   logic [31:0] rdReg;
   wire         busReq  = avs_read | avs_write;
   wire         wrFire  = avs_write && busReg == dhdc_pkg::DHDC_BUS_ANSWER;
   wire         wrCmd   = wrFire && avs_address == `DHDC_OFF_CMD;
   wire         backupEntry = backup && !backupPrevReg;
   wire [3:0]   aHi = avs_address[7:4];
   wire [2:0]   aIdx = avs_address[4:2];

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ctrlReg <= '0; masksReg <= '0; avgLenReg <= `DHDC_AVGLEN_RST;
         for (int i = 0; i < 6; i++) thrReg[i] <= '0;
      end else if (wrFire) begin
         if (avs_address == `DHDC_OFF_CTRL)   ctrlReg   <= avs_writedata;
         if (avs_address == `DHDC_OFF_MASKS)  masksReg  <= avs_writedata;
         if (avs_address == `DHDC_OFF_AVGLEN) avgLenReg <= avs_writedata[11:0];
         for (int i = 0; i < 6; i++)
            if ({aHi[3:1], 1'b0} == `DHDC_BASE_THR && {aHi[0], aIdx[1:0]} == 3'(i))
               thrReg[i] <= avs_writedata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ractReg <= '0;
         backupPrevReg <= 1'b0;
      end else begin
         backupPrevReg <= backup;
         if (backupEntry)
            ractReg <= '0;
         else if (wrFire && avs_address == `DHDC_OFF_RACT)
            ractReg <= avs_writedata[5:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rstOutReg <= '0; rstTmrReg <= '0; diagReg <= 1'b0;
      end else begin
         diagReg <= wrCmd && avs_writedata[`DHDC_CMD_DIAG];
         if (wrCmd && avs_writedata[5:0] != 6'h0) begin
            rstOutReg <= rstOutReg | avs_writedata[5:0];
            rstTmrReg <= `DHDC_RST_TICKS;
         end else if (tickReg && rstTmrReg != 4'h0) begin
            rstTmrReg <= rstTmrReg - 4'h1;
            if (rstTmrReg == 4'h1) rstOutReg <= '0;
         end
      end
   end

   // per-detector diagnostics
   logic [15:0] idleMinReg [6];
   logic [7:0]  presMinReg [6];
   logic [7:0]  actCntReg  [6];
   dhdc_pkg::dhdc_det_vec_t errFltReg, physPrevReg;
   wire  dhdc_pkg::dhdc_det_vec_t rise = detPhys & ~physPrevReg;
   logic [5:0]  ctrlFlt [6];
   logic [4:0]  repFlt  [6];
   dhdc_pkg::dhdc_det_vec_t alarm;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         ctrlFlt[i][`DHDC_F_NOACT]   = thrReg[i][15:0] != 16'h0 && idleMinReg[i] >= thrReg[i][15:0];
         ctrlFlt[i][`DHDC_F_MAXPRES] = thrReg[i][23:16] != 8'h0 && presMinReg[i] >= thrReg[i][23:16];
         ctrlFlt[i][`DHDC_F_ERRATIC] = errFltReg[i];
         ctrlFlt[i][`DHDC_F_COMM]    = commF[i];
         ctrlFlt[i][`DHDC_F_CONFIG]  = masksReg[12 + i] && !present[i];
         ctrlFlt[i][`DHDC_F_OTHER]   = otherF[i];
         repFlt[i] = (i < 4) ? detRep[5*(i%4) +: 5] : 5'h0;
         alarm[i]  = |ctrlFlt[i] || |repFlt[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         errFltReg <= '0; physPrevReg <= '0;
         for (int i = 0; i < 6; i++) begin
            idleMinReg[i] <= '0; presMinReg[i] <= '0; actCntReg[i] <= '0;
         end
      end else begin
         physPrevReg <= detPhys;
         for (int i = 0; i < 6; i++) begin
            if (diagReg) begin
               idleMinReg[i] <= '0; presMinReg[i] <= '0; actCntReg[i] <= '0;
               errFltReg[i]  <= minTickReg && thrReg[i][31:24] != 8'h0 && actCntReg[i] > thrReg[i][31:24];
            end else begin
               if (rise[i]) idleMinReg[i] <= '0;
               else if (minTickReg && idleMinReg[i] != `DHDC_CNT_MAX) idleMinReg[i] <= idleMinReg[i] + 16'h1;
               if (!detPhys[i]) presMinReg[i] <= '0;
               else if (minTickReg && presMinReg[i] != `DHDC_BYTE_MAX) presMinReg[i] <= presMinReg[i] + 8'h1;
               // actuations per minute against erratic count
               if (minTickReg) begin
                  actCntReg[i] <= {7'h0, rise[i]};
                  errFltReg[i] <= thrReg[i][31:24] != 8'h0 && actCntReg[i] > thrReg[i][31:24];
               end else if (rise[i] && actCntReg[i] != `DHDC_BYTE_MAX) begin
                  actCntReg[i] <= actCntReg[i] + 8'h1;
               end
            end
         end
      end
   end

   // sample periods: index 0 vehicle, 1 pedestrian
   logic [15:0] durReg [2];
   logic [15:0] secCntReg [2];
   logic [7:0]  seqReg [2];
   logic [31:0] endTimeReg [2];
   logic [1:0]  periodEnd;
   logic [15:0] durWant [2];
   always_comb begin
      durWant[0] = periodSecs(ctrlReg[15:0], durReg[0], coordActive, cycleLength);
      durWant[1] = periodSecs(ctrlReg[31:16], durReg[0], coordActive, cycleLength);
      for (int k = 0; k < 2; k++)
         periodEnd[k] = secTickReg && durReg[k] != 16'h0 && secCntReg[k] == durReg[k] - 16'h1;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         for (int k = 0; k < 2; k++) begin
            durReg[k] <= '0; secCntReg[k] <= '0; seqReg[k] <= '0; endTimeReg[k] <= '0;
         end
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (durReg[k] == 16'h0) begin
               if (secTickReg) begin
                  durReg[k] <= durWant[k];
                  secCntReg[k] <= '0;
               end
            end else if (periodEnd[k]) begin
               seqReg[k]     <= seqReg[k] + 8'h1;
               endTimeReg[k] <= localTime;
               durReg[k]     <= durWant[k];
               secCntReg[k]  <= '0;
            end else if (secTickReg) begin
               secCntReg[k]  <= secCntReg[k] + 16'h1;
            end
         end
      end
   end

   // vehicle data accumulation
   logic [15:0] volAccReg [4];
   logic [15:0] onAccReg  [4];
   logic [15:0] totAccReg;
   logic [31:0] dataReg   [4];
   logic [15:0] repDurReg;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         totAccReg <= '0; repDurReg <= '0;
         for (int i = 0; i < 4; i++) begin
            volAccReg[i] <= '0; onAccReg[i] <= '0; dataReg[i] <= '0;
         end
      end else if (periodEnd[0]) begin
         totAccReg <= '0;
         repDurReg <= durReg[0];
         for (int i = 0; i < 4; i++) begin
            dataReg[i][15:0]  <= masksReg[i] ? volAccReg[i] : 16'h0;
            dataReg[i][23:16] <= masksReg[4 + i] ? occCalc(onAccReg[i], totAccReg) : 8'h0;
            dataReg[i][31:24] <= masksReg[8 + i] ? spdCalc(volAccReg[i], avgLenReg, onAccReg[i]) : 8'h0;
            volAccReg[i] <= '0;
            onAccReg[i]  <= '0;
         end
      end else if (durReg[0] != 16'h0) begin
         if (tickReg) totAccReg <= totAccReg + 16'h1;
         for (int i = 0; i < 4; i++) begin
            if (rise[i] && volAccReg[i] != `DHDC_CNT_MAX) volAccReg[i] <= volAccReg[i] + 16'h1;
            if (tickReg && detPhys[i]) onAccReg[i] <= onAccReg[i] + 16'h1;
         end
      end
   end

   // calls and reset pins, all registered
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         vehCall <= '0; pedCall <= '0; vehDetReset <= '0; pedDetReset <= '0;
      end else begin
         vehCall     <= detPhys[3:0] | ractReg[3:0];
         pedCall     <= detPhys[5:4] | ractReg[5:4];
         vehDetReset <= rstOutReg[3:0];
         pedDetReset <= rstOutReg[5:4];
      end
   end

   // read decode
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0;
      case (avs_address)
         `DHDC_OFF_CTRL:   rdMux = ctrlReg;
         `DHDC_OFF_MASKS:  rdMux = {14'h0, masksReg[17:0]};
         `DHDC_OFF_AVGLEN: rdMux = {20'h0, avgLenReg};
         `DHDC_OFF_CMD:    rdMux = {26'h0, rstOutReg};
         `DHDC_OFF_RACT:   rdMux = {26'h0, ractReg};
         `DHDC_OFF_ALARM:  rdMux = {26'h0, alarm};
         `DHDC_OFF_SEQ:    rdMux = {16'h0, seqReg[1], seqReg[0]};
         `DHDC_OFF_VEND:   rdMux = endTimeReg[0];
         `DHDC_OFF_DUR:    rdMux = {durReg[1], repDurReg};
         `DHDC_OFF_PEND:   rdMux = endTimeReg[1];
         default: begin
            for (int i = 0; i < 6; i++) begin
               if ({aHi[3:1], 1'b0} == `DHDC_BASE_THR && {aHi[0], aIdx[1:0]} == 3'(i))
                  rdMux = thrReg[i];
               if ({aHi[3:1], 1'b0} == `DHDC_BASE_FLT && {aHi[0], aIdx[1:0]} == 3'(i))
                  rdMux = {19'h0, repFlt[i], 2'h0, ctrlFlt[i]};
            end
            for (int i = 0; i < 4; i++)
               if (aHi == `DHDC_BASE_DATA && aIdx == 3'(i))
                  rdMux = dataReg[i];
         end
      endcase
   end

   // one wait state: request seen, answer next cycle
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         busReg <= dhdc_pkg::DHDC_BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         case (busReg)
            dhdc_pkg::DHDC_BUS_IDLE: begin
               if (busReq) begin
                  busReg <= dhdc_pkg::DHDC_BUS_ANSWER;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= avs_read ? rdMux : 32'h0;
               end
            end
            dhdc_pkg::DHDC_BUS_ANSWER: begin
               busReg <= dhdc_pkg::DHDC_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: busReg <= dhdc_pkg::DHDC_BUS_IDLE;
         endcase
      end
   end

endmodule : dhdc_top

// ---- verif/dhdc_det_model.sv ----
// Purpose: contact-closure detectors on the far side of the block
// Assumes: one actuation is 8 clocks closed, then 7 clocks open
// Notes:   an idle contact reads open (low), never the last value
`timescale 1ns/1ns
module dhdc_det_model (
   input  wire logic       core_clk,
   input  wire logic       pulseReq,
   input  wire logic [5:0] pulseMask,
   output logic [3:0]      vehDetIn,
   output logic [1:0]      pedDetIn,
   output logic            busy
);
   logic [3:0] phase_reg = 4'h0;
   logic [5:0] mask_reg = 6'h00;
   assign busy = phase_reg != 4'h0;
   // open phase keeps actuations countable by the block's filter
   assign vehDetIn = phase_reg[3] ? mask_reg[3:0] : 4'h0;
   assign pedDetIn = phase_reg[3] ? mask_reg[5:4] : 2'h0;
   always_ff @(posedge core_clk) begin
      if (pulseReq && !busy) begin
         phase_reg <= 4'hF;
         mask_reg <= pulseMask;
      end else if (busy) begin
         phase_reg <= phase_reg - 4'h1;
      end
   end
endmodule : dhdc_det_model

// ---- verif/dhdc_top_props.sv ----
// Purpose: port-level properties of dhdc_top
// Assumes: one wait state per access, detector reset near 50 clocks
// Notes:   bound to dhdc_top below
`timescale 1ns/1ns
module dhdc_top_props (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [3:0]  vehDetIn,
   input wire logic [1:0]  pedDetIn,
   input wire logic        backupMode,
   input wire logic [3:0]  vehDetReset,
   input wire logic [1:0]  pedDetReset,
   input wire logic [3:0]  vehCall,
   input wire logic [1:0]  pedCall
);
   logic [7:0] rstLen_reg;
   logic [7:0] rstLen_next;
   assign rstLen_next = (|{vehDetReset, pedDetReset}) ? rstLen_reg + {7'h00, rstLen_reg != 8'hFF} : 8'h00;
   always_ff @(posedge core_clk) rstLen_reg <= !reset_n ? 8'h00 : rstLen_next;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer stood longer than one cycle");
   ans_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without a request");
   ans_bound_a: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
      else $error("request not answered in time");
   write_zero_a: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h00000000)
      else $error("write answer carried data");
   rd_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
      else $error("read data moved between answers");
   rst_return_a: assert property (rstLen_reg <= 8'h3C)
      else $error("detector reset did not return");
   phys_call_a: assert property (vehDetIn[0] [*8] |-> vehCall[0])
      else $error("contact closure not passed to call");
   backup_clr_a: assert property ((backupMode && vehDetIn == 4'h0 && pedDetIn == 2'h0) [*8] |->
      vehCall == 4'h0 && pedCall == 2'h0)
      else $error("remote actuation kept in backup");
   cover property (avs_read && !avs_waitrequest);
   cover property (rstLen_reg == 8'h28);
   cover property ($rose(backupMode));
endmodule : dhdc_top_props
bind dhdc_top dhdc_top_props i_dhdc_top_props (.core_clk(core_clk), .reset_n(reset_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vehDetIn(vehDetIn),
   .pedDetIn(pedDetIn), .backupMode(backupMode), .vehDetReset(vehDetReset), .pedDetReset(pedDetReset),
   .vehCall(vehCall), .pedCall(pedCall));

// ---- verif/dhdc_top_tb_top.sv ----
// Purpose: register-level tests of dhdc_top
// Assumes: TICK_CYCLES 10, so one second is 100 clocks
// Notes:   localTime counts clocks, so end times differ by the period
`timescale 1ns/1ns
`include "dhdc_consts.svh"
module dhdc_top_tb_top;
   logic        core_clk = 1'h0;
   logic        reset_n = 1'h0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'h0;
   logic        avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [3:0]  vehDetIn, vehDetReset, vehCall;
   logic [1:0]  pedDetIn, pedDetReset, pedCall;
   logic [5:0]  detCommFail = 6'h00, detOtherFault = 6'h00, detPresent = 6'h3F, pulseMask = 6'h00;
   logic [19:0] vehDetFaultIn = 20'h00000;
   logic        backupMode = 1'h0, pulseReq = 1'h0, busy;
   logic        coordActive = 1'h0;
   logic [15:0] cycleLength = 16'h0000;
   logic [31:0] localTime = 32'h0, q, seq0, t0;
   int          fails = 0, n_compared = 0, i;
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) localTime <= localTime + 32'h1;
   dhdc_top #(.TICK_CYCLES(10)) i_dhdc_top (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .vehDetIn(vehDetIn), .pedDetIn(pedDetIn), .detCommFail(detCommFail),
      .detOtherFault(detOtherFault), .detPresent(detPresent), .vehDetFaultIn(vehDetFaultIn),
      .backupMode(backupMode), .coordActive(coordActive), .cycleLength(cycleLength), .localTime(localTime),
      .vehDetReset(vehDetReset), .pedDetReset(pedDetReset), .vehCall(vehCall), .pedCall(pedCall));
   dhdc_det_model i_dhdc_det_model (.core_clk(core_clk), .pulseReq(pulseReq), .pulseMask(pulseMask),
      .vehDetIn(vehDetIn), .pedDetIn(pedDetIn), .busy(busy));
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      r = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (n >= 50) begin
         fails++;
         results();
      end
      @(posedge core_clk);
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'h0, a, 32'h0, r);
      chk(r, exp);
   endtask : rdc
   task automatic pulse(input logic [5:0] m, input int n);
      repeat (n) begin
         pulseReq <= 1'h1;
         pulseMask <= m;
         @(posedge core_clk);
         pulseReq <= 1'h0;
         i = 0;
         do begin
            @(posedge core_clk);
            i++;
         end while ((busy || i < 2) && i < 30);
         if (i >= 30) begin
            fails++;
            results();
         end
      end
   endtask : pulse
   task automatic nextSeq();
      int n = 0;
      bus(1'h0, `DHDC_OFF_SEQ, 32'h0, seq0);
      do begin
         bus(1'h0, `DHDC_OFF_SEQ, 32'h0, q);
         n++;
      end while (q[7:0] === seq0[7:0] && n < 100);
      if (n >= 100) begin
         fails++;
         results();
      end
   endtask : nextSeq
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'h1;
      @(posedge core_clk);
      rdc(`DHDC_OFF_AVGLEN, 32'h000001C2);
      rdc(8'hFC, 32'h0);
      bus(1'h1, `DHDC_OFF_ALARM, 32'h3F, q);
      rdc(`DHDC_OFF_ALARM, 32'h0);
      $display("reset and map test done");
      bus(1'h1, `DHDC_OFF_RACT, 32'h3F, q);
      repeat (8) @(posedge core_clk);
      chk({vehCall, pedCall}, 32'h3F);
      backupMode <= 1'h1;
      repeat (10) @(posedge core_clk);
      chk({vehCall, pedCall}, 32'h0);
      rdc(`DHDC_OFF_RACT, 32'h0);
      backupMode <= 1'h0;
      $display("remote actuation test done");
      bus(1'h1, `DHDC_OFF_CMD, 32'h3F, q);
      rdc(`DHDC_OFF_CMD, 32'h3F);
      chk({vehDetReset, pedDetReset}, 32'h3F);
      repeat (70) @(posedge core_clk);
      chk({vehDetReset, pedDetReset}, 32'h0);
      rdc(`DHDC_OFF_CMD, 32'h0);
      $display("detector reset test done");
      detCommFail <= 6'h12;
      detOtherFault <= 6'h08;
      vehDetFaultIn <= 20'h00015;
      detPresent <= 6'h3B;
      bus(1'h1, `DHDC_OFF_MASKS, 32'h00004000, q);
      repeat (10) @(posedge core_clk);
      rdc(8'h60, 32'h00001500);
      rdc(8'h64, 32'h08);
      rdc(8'h68, 32'h10);
      rdc(8'h6C, 32'h20);
      rdc(8'h70, 32'h08);
      rdc(`DHDC_OFF_ALARM, 32'h1F);
      detCommFail <= 6'h00;
      detOtherFault <= 6'h00;
      vehDetFaultIn <= 20'h00000;
      detPresent <= 6'h3F;
      bus(1'h1, `DHDC_OFF_MASKS, 32'h00000111, q);
      repeat (10) @(posedge core_clk);
      rdc(`DHDC_OFF_ALARM, 32'h0);
      $display("fault report test done");
      bus(1'h1, 8'h40, 32'h02000000, q);
      bus(1'h1, `DHDC_OFF_CTRL, 32'hFFFE0001, q);
      nextSeq();
      bus(1'h0, `DHDC_OFF_VEND, 32'h0, t0);
      pulse(6'h03, 3);
      bus(1'h1, `DHDC_OFF_RACT, 32'h01, q);
      bus(1'h1, `DHDC_OFF_RACT, 32'h00, q);
      nextSeq();
      rdc(`DHDC_OFF_DUR, 32'h00010001);
      bus(1'h0, `DHDC_OFF_VEND, 32'h0, q);
      chk(q - t0, 32'h64);
      bus(1'h0, 8'h80, 32'h0, q);
      chk(q[15:0], 32'h3);
      chk(q[23:16] <= 8'hC8, 32'h1);
      rdc(8'h84, 32'h0);
      $display("period data test done");
      for (int k = 0; k < 260; k++) begin
         nextSeq();
         chk(q[7:0], 8'(seq0[7:0] + 8'h01));
         chk(q[15:8], 8'(seq0[15:8] + 8'h01));
      end
      $display("sequence wrap test done");
      coordActive <= 1'h1;
      cycleLength <= 16'h0002;
      bus(1'h1, `DHDC_OFF_CTRL, 32'h0000FFFF, q);
      nextSeq();
      bus(1'h0, `DHDC_OFF_VEND, 32'h0, t0);
      nextSeq();
      bus(1'h0, `DHDC_OFF_DUR, 32'h0, q);
      chk(q[15:0], 32'h2);
      bus(1'h0, `DHDC_OFF_VEND, 32'h0, q);
      chk(q - t0, 32'hC8);
      $display("cycle length period test done");
      pulse(6'h03, 6);
      i = 0;
      do begin
         bus(1'h0, 8'h60, 32'h0, q);
         i++;
      end while (q[2] !== 1'h1 && i < 3000);
      chk(q[2], 32'h1);
      rdc(8'h64, 32'h0);
      bus(1'h1, `DHDC_OFF_CMD, 32'h100, q);
      rdc(8'h60, 32'h0);
      rdc(8'h40, 32'h02000000);
      $display("diagnostic test done");
      results();
   end
endmodule : dhdc_top_tb_top
